// ==== common/asrm_map.vh ====
// timing and field constants for the static memory access controller
`ifndef ASRM_MAP_VH
`define ASRM_MAP_VH
`define ASRM_CLK_PERIOD_NS     10
`define ASRM_T_READ_ADDR_NS    45
`define ASRM_T_WRITE_PULSE_NS  35
`define ASRM_T_WFLOAT_NS       18
`define ASRM_T_WSETUP_NS       25
`define ASRM_T_RECOVER_NS      10
`define ASRM_SYNC_STAGES       2
`define ASRM_LO_BYTE_MSB       7
`define ASRM_HI_BYTE_LSB       8
`define ASRM_LANE_BITS         2
`define ASRM_LANE_NONE         2'h3
`define ASRM_LANE_LO           2'h2
`define ASRM_LANE_HI           2'h1
`define ASRM_LANE_BOTH         2'h0
`endif

// ==== src/asrm_cycle_timer.v ====
// down-counter timing one phase of a memory cycle
`timescale 1ns/10ps
module asrm_cycle_timer #(
    parameter WIDTH = 4
) (
    input  wire             sys_clk_in,
    input  wire             sys_rst_in,
    input  wire             load_in,
    input  wire [WIDTH-1:0] count_in,
    output wire             done_out
);
    reg [WIDTH-1:0] cnt_q;
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != {WIDTH{1'b0}}) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    // no path from load back to done, so a reload on done cannot loop
    assign done_out = (cnt_q == {WIDTH{1'b0}});
endmodule // asrm_cycle_timer

// ==== src/asrm_host.v ====
// host controller driving an asynchronous static memory with error flag
`timescale 1ns/10ps
`include "asrm_map.vh"
module asrm_host #(
    parameter ADDR_W = 21,
    parameter DATA_W = 16
) (
    input  wire              sys_clk_in,
    input  wire              sys_rst_in,
    input  wire              wide_mode_in,
    input  wire              req_valid_in,
    input  wire              req_write_in,
    input  wire [ADDR_W-1:0] req_addr_in,
    input  wire [DATA_W-1:0] req_wdata_in,
    input  wire [1:0]        req_lanes_in,
    output reg               req_ready_out,
    output reg               rsp_valid_out,
    output reg  [DATA_W-1:0] rsp_rdata_out,
    output reg               rsp_corrected_out,
    output reg  [ADDR_W-1:0] mem_addr_out,
    output reg               select_low_active_n_out,
    output reg               select_high_active_out,
    output reg               write_en_n_out,
    output reg               out_en_n_out,
    output reg               upper_lane_n_out,
    output reg               lower_lane_n_out,
    output reg               width_sel_out,
    output reg  [DATA_W-1:0] mem_dq_out,
    output reg  [DATA_W-1:0] mem_dq_oe_out,
    input  wire [DATA_W-1:0] mem_dq_in,
    input  wire              mem_err_in
);
    ////////////////////////////////////////////////////////////////////////
    localparam integer RD_CYC = (`ASRM_T_READ_ADDR_NS + `ASRM_CLK_PERIOD_NS - 1)
                                / `ASRM_CLK_PERIOD_NS + `ASRM_SYNC_STAGES;
    localparam integer WR_CYC = (`ASRM_T_WRITE_PULSE_NS + `ASRM_CLK_PERIOD_NS - 1)
                                / `ASRM_CLK_PERIOD_NS;
    localparam integer FL_CYC = (`ASRM_T_WFLOAT_NS + `ASRM_CLK_PERIOD_NS - 1)
                                / `ASRM_CLK_PERIOD_NS;
    localparam integer SU_CYC = (`ASRM_T_WSETUP_NS + `ASRM_CLK_PERIOD_NS - 1)
                                / `ASRM_CLK_PERIOD_NS;
    localparam integer RC_CYC = (`ASRM_T_RECOVER_NS + `ASRM_CLK_PERIOD_NS - 1)
                                / `ASRM_CLK_PERIOD_NS;
    localparam [3:0] RD_CNT = RD_CYC[3:0];
    localparam [3:0] FL_CNT = FL_CYC[3:0];
    localparam integer SU_SEL = (WR_CYC > FL_CYC + SU_CYC) ? (WR_CYC - FL_CYC) : SU_CYC;
    localparam [3:0] SU_CNT = SU_SEL[3:0];
    localparam [3:0] RC_CNT = RC_CYC[3:0];

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_READ  = 3'h1;
    localparam [2:0] ST_WFLT  = 3'h2;
    localparam [2:0] ST_WDAT  = 3'h3;
    localparam [2:0] ST_REC   = 3'h4;

    // lane pattern for pins; narrow mode ignores lanes
    function [DATA_W-1:0] lane_mask;
        input       wide;
        input [1:0] lanes;
        begin
            lane_mask = {DATA_W{1'b0}};
            if (!wide || !lanes[0]) begin
                lane_mask[`ASRM_LO_BYTE_MSB:0] = {(`ASRM_LO_BYTE_MSB+1){1'b1}};
            end
            if (wide && !lanes[1]) begin
                lane_mask[DATA_W-1:`ASRM_HI_BYTE_LSB] =
                    {(DATA_W-`ASRM_HI_BYTE_LSB){1'b1}};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    reg  [DATA_W-1:0] dq_s1_q, dq_s2_q;
    reg               err_s1_q, err_s2_q;
    reg  [2:0]        state_q;
    reg               wide_q;
    reg  [1:0]        lanes_q;
    reg               tload;
    reg  [3:0]        tcount;
    wire              tdone;
    wire [DATA_W-1:0] mask_w = lane_mask(wide_q, lanes_q);

    asrm_cycle_timer #(.WIDTH(4)) u_timer (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (tload),
        .count_in   (tcount),
        .done_out   (tdone)
    );

    // pins from outside pass two flops
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dq_s1_q  <= {DATA_W{1'b0}};
            dq_s2_q  <= {DATA_W{1'b0}};
            err_s1_q <= 1'b0;
            err_s2_q <= 1'b0;
        end else begin
            dq_s1_q  <= mem_dq_in;
            dq_s2_q  <= dq_s1_q;
            err_s1_q <= mem_err_in;
            err_s2_q <= err_s1_q;
        end
    end

    always @* begin
        tload  = 1'b0;
        tcount = 4'h0;
        case (state_q)
            ST_IDLE: begin
                tload  = req_valid_in;
                tcount = req_write_in ? FL_CNT : RD_CNT;
            end
            ST_WFLT: begin
                tload  = tdone;
                tcount = SU_CNT;
            end
            ST_READ, ST_WDAT: begin
                tload  = tdone;
                tcount = RC_CNT;
            end
            default: begin
                tload  = 1'b0;
                tcount = 4'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q                 <= ST_IDLE;
            wide_q                  <= 1'b1;
            lanes_q                 <= `ASRM_LANE_NONE;
            req_ready_out           <= 1'b0;
            rsp_valid_out           <= 1'b0;
            rsp_rdata_out           <= {DATA_W{1'b0}};
            rsp_corrected_out       <= 1'b0;
            mem_addr_out            <= {ADDR_W{1'b0}};
            select_low_active_n_out <= 1'b1;
            select_high_active_out  <= 1'b0;
            write_en_n_out          <= 1'b1;
            out_en_n_out            <= 1'b1;
            upper_lane_n_out        <= 1'b1;
            lower_lane_n_out        <= 1'b1;
            width_sel_out           <= 1'b1;
            mem_dq_out              <= {DATA_W{1'b0}};
            mem_dq_oe_out           <= {DATA_W{1'b0}};
        end else begin
            rsp_valid_out <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    req_ready_out <= 1'b1;
                    // strap follows input only between cycles
                    wide_q        <= wide_mode_in;
                    width_sel_out <= wide_mode_in;
                    if (req_valid_in && req_ready_out) begin
                        req_ready_out <= 1'b0;
                        // strap frozen at the take so lanes and width agree
                        wide_q        <= wide_q;
                        width_sel_out <= wide_q;
                        lanes_q       <= wide_q ? req_lanes_in : `ASRM_LANE_BOTH;
                        // address set with select, stable all cycle
                        mem_addr_out            <= req_addr_in;
                        select_low_active_n_out <= 1'b0;
                        select_high_active_out  <= 1'b1;
                        upper_lane_n_out <= wide_q ? req_lanes_in[1] : 1'b0;
                        lower_lane_n_out <= wide_q ? req_lanes_in[0] : 1'b0;
                        mem_dq_out       <= req_wdata_in;
                        if (req_write_in) begin
                            // write enable low with all strobes: write starts
                            write_en_n_out <= 1'b0;
                            out_en_n_out   <= 1'b1;
                            state_q        <= ST_WFLT;
                        end else begin
                            write_en_n_out <= 1'b1;
                            out_en_n_out   <= 1'b0;
                            state_q        <= ST_READ;
                        end
                    end
                end
                ST_WFLT: begin
                    // wait out float delay before driving pins
                    if (tdone) begin
                        mem_dq_oe_out <= mask_w;
                        state_q       <= ST_WDAT;
                    end
                end
                ST_WDAT: begin
                    // pulse covers float plus setup; write enable ends it
                    if (tdone) begin
                        write_en_n_out <= 1'b1;
                        state_q        <= ST_REC;
                    end
                end
                ST_READ: begin
                    // sample after address and enable access time
                    if (tdone) begin
                        rsp_rdata_out     <= dq_s2_q & mask_w;
                        rsp_corrected_out <= err_s2_q;
                        rsp_valid_out     <= 1'b1;
                        out_en_n_out      <= 1'b1;
                        state_q           <= ST_REC;
                    end
                end
                ST_REC: begin
                    // data held past write end, then everything released
                    mem_dq_oe_out           <= {DATA_W{1'b0}};
                    select_low_active_n_out <= 1'b1;
                    select_high_active_out  <= 1'b0;
                    upper_lane_n_out        <= 1'b1;
                    lower_lane_n_out        <= 1'b1;
                    if (tdone) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // asrm_host

// ==== tb/asrm_host_chk.sv ====
// pin-level timing checks on the static memory controller
`timescale 1ns/10ps
module asrm_host_chk #(
    parameter ADDR_W = 21,
    parameter DATA_W = 16
) (
    input wire              sys_clk_in,
    input wire              sys_rst_in,
    input wire              req_valid_in,
    input wire              req_write_in,
    input wire              req_ready_out,
    input wire              rsp_valid_out,
    input wire [ADDR_W-1:0] mem_addr_out,
    input wire              select_low_active_n_out,
    input wire              select_high_active_out,
    input wire              write_en_n_out,
    input wire              out_en_n_out,
    input wire              upper_lane_n_out,
    input wire              lower_lane_n_out,
    input wire              width_sel_out,
    input wire [DATA_W-1:0] mem_dq_oe_out
);
    wire cs = !select_low_active_n_out && select_high_active_out;
    wire drv = |mem_dq_oe_out;
    wire tk = req_valid_in && req_ready_out;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////
    property p_rd_lat; tk && !req_write_in |-> ##9 rsp_valid_out; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_open; tk && !req_write_in |-> ##1 cs && !out_en_n_out; endproperty
    a_rd_open: assert property (p_rd_open) else $error("read not opened");
    property p_rd_we; $fell(out_en_n_out) && write_en_n_out |-> write_en_n_out [*6]; endproperty
    a_rd_we: assert property (p_rd_we) else $error("write strobe in read");
    property p_wr_open; tk && req_write_in |-> ##1 cs && !write_en_n_out; endproperty
    a_wr_open: assert property (p_wr_open) else $error("write not opened");
    property p_addr; cs && $past(cs) |-> $stable(mem_addr_out) && $stable(width_sel_out); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_pulse; $fell(write_en_n_out) |-> (!write_en_n_out) [*4]; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse short");
    property p_pulse_oe; $fell(write_en_n_out) |-> (!write_en_n_out) [*5]; endproperty
    a_pulse_oe: assert property (p_pulse_oe) else $error("pulse short");
    property p_setup; $rose(write_en_n_out) |-> drv && $past(drv, 3); endproperty
    a_setup: assert property (p_setup) else $error("data setup short");
    property p_clash; drv |-> out_en_n_out || $past(write_en_n_out, 2) == 1'b0; endproperty
    a_clash: assert property (p_clash) else $error("bus clash");
    property p_lanes; drv && width_sel_out && !write_en_n_out |->
        mem_dq_oe_out == {{8{!upper_lane_n_out}}, {8{!lower_lane_n_out}}}; endproperty
    a_lanes: assert property (p_lanes) else $error("lane drive wrong");
    property p_narrow; drv && !width_sel_out |-> mem_dq_oe_out[DATA_W-1:8] == 8'h00; endproperty
    a_narrow: assert property (p_narrow) else $error("upper byte driven");
    c_rd: cover property (tk && !req_write_in ##9 rsp_valid_out);
    c_wr: cover property ($rose(write_en_n_out));
    c_nar: cover property (drv && !width_sel_out);
endmodule // asrm_host_chk
bind asrm_host asrm_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_asrm_host_chk (.*);

// ==== tb/asrm_mem_model.sv ====
// behavioural static memory with error flag, far side of the controller
`timescale 1ns/10ps
module asrm_mem_model #(
    parameter T_RD = 20
) (
    input  wire [20:0] addr_in,
    input  wire        sel_lo_n_in,
    input  wire        sel_hi_in,
    input  wire        we_n_in,
    input  wire        oe_n_in,
    input  wire        up_n_in,
    input  wire        lo_n_in,
    input  wire        width_in,
    input  wire [15:0] dq_in,
    input  wire [15:0] dq_oe_in,
    output wire [15:0] dq_out,
    output wire        err_out
);
    reg  [15:0] word_q [0:255];
    reg  [7:0]  byte_q [0:255];
    reg         flip_q [0:255];
    wire [26:0] late;
    wire        cs = !sel_lo_n_in && sel_hi_in;
    wire        on = cs && !(width_in && up_n_in && lo_n_in);
    wire        wr = on && !we_n_in && (!width_in || !up_n_in || !lo_n_in);
    wire        rd = on && we_n_in && !oe_n_in;
    wire [7:0]  a = addr_in[7:0];
    wire [15:0] en = !rd ? 16'h0 : !width_in ? 16'h00ff : {{8{!up_n_in}}, {8{!lo_n_in}}};
    wire [15:0] cur = width_in ? word_q[a] : {8'h00, byte_q[a]};
    // floating pins show the inverse of the stored data at the current address
    assign #T_RD dq_out = cur ~^ en;
    assign #T_RD err_out = flip_q[a] ~^ rd;
    // pins as they stood just before the window closed
    assign #1 late = {width_in, up_n_in, lo_n_in, a, dq_in ~^ dq_oe_in};
    initial begin
        for (int i = 0; i < 256; i++) begin
            word_q[i] = 16'h0;
            byte_q[i] = 8'h0;
            flip_q[i] = 1'b0;
        end
    end
    always @(negedge wr) begin
        if (!late[26])
            byte_q[late[23:16]] <= late[7:0];
        if (late[26] && !late[24])
            word_q[late[23:16]][7:0] <= late[7:0];
        if (late[26] && !late[25])
            word_q[late[23:16]][15:8] <= late[15:8];
    end
endmodule // asrm_mem_model

// ==== tb/testbench.sv ====
// self-checking bench for the static memory controller
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic        w;
        logic        wide;
        logic        flip;
        logic [7:0]  a;
        logic [15:0] d;
        logic [1:0]  ln;
        logic [15:0] exp;
        logic [15:0] mask;
        logic        err;
    } asrm_row_t;
    asrm_row_t rows [0:8] = '{
        '{1, 1, 0, 8'h05, 16'ha5c3, 2'h0, 16'h0, 16'h0, 0},
        '{0, 1, 0, 8'h05, 16'h0, 2'h0, 16'ha5c3, 16'hffff, 0},
        '{1, 1, 0, 8'h05, 16'h1177, 2'h2, 16'h0, 16'h0, 0},
        '{0, 1, 0, 8'h05, 16'h0, 2'h1, 16'ha500, 16'hffff, 0},
        '{1, 1, 0, 8'h05, 16'hee00, 2'h1, 16'h0, 16'h0, 0},
        '{0, 1, 0, 8'h05, 16'h0, 2'h2, 16'h0077, 16'hffff, 0},
        '{0, 1, 1, 8'h05, 16'h0, 2'h0, 16'hee77, 16'hffff, 1},
        '{1, 0, 0, 8'h09, 16'h12bb, 2'h3, 16'h0, 16'h0, 0},
        '{0, 0, 0, 8'h09, 16'h0, 2'h3, 16'h00bb, 16'h00ff, 0}};
    logic        clk, rst, wide, vld, wr;
    logic [20:0] addr;
    logic [15:0] wd;
    logic [1:0]  lanes;
    wire         ready, rsp_valid, corr, sel_n, sel_h, we_n, oe_n, up_n, lo_n, width, err;
    wire  [20:0] mem_addr;
    wire  [15:0] rdata, dq_o, dq_oe, dq_i;
    int          checks = 0;
    int          num_errors = 0;
    asrm_host u_asrm_host (.sys_clk_in(clk), .sys_rst_in(rst), .wide_mode_in(wide),
        .req_valid_in(vld), .req_write_in(wr), .req_addr_in(addr), .req_wdata_in(wd),
        .req_lanes_in(lanes), .req_ready_out(ready), .rsp_valid_out(rsp_valid),
        .rsp_rdata_out(rdata), .rsp_corrected_out(corr), .mem_addr_out(mem_addr),
        .select_low_active_n_out(sel_n), .select_high_active_out(sel_h),
        .write_en_n_out(we_n), .out_en_n_out(oe_n), .upper_lane_n_out(up_n),
        .lower_lane_n_out(lo_n), .width_sel_out(width), .mem_dq_out(dq_o),
        .mem_dq_oe_out(dq_oe), .mem_dq_in(dq_i), .mem_err_in(err));
    asrm_mem_model u_asrm_mem_model (.addr_in(mem_addr), .sel_lo_n_in(sel_n),
        .sel_hi_in(sel_h), .we_n_in(we_n), .oe_n_in(oe_n), .up_n_in(up_n),
        .lo_n_in(lo_n), .width_in(width), .dq_in(dq_o), .dq_oe_in(dq_oe),
        .dq_out(dq_i), .err_out(err));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic run(input asrm_row_t r);
        int n;
        n = 0;
        u_asrm_mem_model.flip_q[r.a] = r.flip;
        @(posedge clk);
        wide <= r.wide;
        @(posedge clk);
        {vld, wr, addr, wd, lanes} <= {1'b1, r.w, 13'h0, r.a, r.d, r.ln};
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'b1 && n < 50);
        chk(n < 50, 1'b1);
        if (n >= 50)
            wrap_up();
        @(posedge clk);
        vld <= 1'b0;
        n = 0;
        if (!r.w) begin
            do begin
                @(negedge clk);
                n++;
            end while (rsp_valid !== 1'b1 && n < 50);
            chk(n[15:0], 16'h9);
            if (n >= 50)
                wrap_up();
            chk(rdata & r.mask, r.exp);
            chk({15'h0, corr}, {15'h0, r.err});
            chk({15'h0, width}, {15'h0, r.wide});
        end
    endtask
    initial begin
        {rst, wide, vld, wr, addr, wd, lanes} = {3'b110, 40'h0};
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({9'h0, sel_n, sel_h, we_n, oe_n, up_n, lo_n, ready}, 16'h005e);
        chk(dq_oe, 16'h0);
        @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
            run(rows[i]);
        // reset in the middle of a read, then the same read again
        @(posedge clk);
        vld <= 1'b1;
        wr  <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        vld <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({9'h0, sel_n, sel_h, we_n, oe_n, up_n, lo_n, ready}, 16'h005e);
        chk({15'h0, rsp_valid}, 16'h0);
        chk(dq_oe, 16'h0);
        @(posedge clk);
        rst <= 1'b0;
        run(rows[8]);
        wrap_up();
    end
endmodule // testbench
